// ===== bench/alu_datapath_asserts.sv
// port checker for the alu datapath: apb timing, page holes, power flags
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ns
module alu_datapath_chk (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        watchdog_timeout_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        power_down_flag_out,
  input wire logic        watchdog_expiry_flag_out
);
  import alu_bit_pkg::*;
  // ****************************************
  // decode and properties
  // ****************************************
  wire       done_w = psel_in && penable_in && pready_out;          // completion edge
  wire       cmd_w  = done_w && pwrite_in && (paddr_in == CMD_OFS); // an op executes here
  wire [3:0] op_w   = pwdata_in[3:0];                               // op field of that write
  wire [3:0] pg_w   = paddr_in[11:8];                               // page window of the access
  // single domain, so one clocking and one disable serve all
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_one_wait: assert property (psel_in && $rose(penable_in) |=> pready_out) else $error("ready late");
  chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready held");
  chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("stale read data");
  chk_ctrl_hole: assert property (done_w && pg_w == CTRL_PAGE && paddr_in[7:2] < CTRL_FIRST |-> pslverr_out)
    else $error("control hole accepted");
  chk_main_span: assert property (done_w && pg_w == MAIN_PAGE && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
    else $error("main cell refused");
  chk_halt_flags: assert property (cmd_w && op_w == OP_HALT |=> !power_down_flag_out)
    else $error("halt kept power flag");
  chk_clear_flags: assert property (cmd_w && op_w == OP_WATCHDOG_CLEAR |=> watchdog_expiry_flag_out)
    else $error("clear left expiry low");
  chk_timeout_clr: assert property (watchdog_timeout_in && !cmd_w |=> !watchdog_expiry_flag_out)
    else $error("timeout ignored");
  chk_pd_cause: assert property ($changed(power_down_flag_out) |-> $past(cmd_w))
    else $error("power flag moved alone");
  cov_cmd: cover property (cmd_w);
  cov_refused: cover property (pslverr_out);
  cov_expiry: cover property (watchdog_timeout_in ##1 !watchdog_expiry_flag_out);
endmodule

bind mcu_alu_bit_datapath alu_datapath_chk chk_u (.clock_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .watchdog_timeout_in, .prdata_out, .pready_out, .pslverr_out, .power_down_flag_out,
  .watchdog_expiry_flag_out);

// ===== bench/test_mcu_alu_bit_datapath.sv
// bench: apb tasks and hand-worked sums for the alu datapath
// assumes the package, the bound checker and the watchdog stand-in
`timescale 1ns/1ns
module test_mcu_alu_bit_datapath;
  import alu_bit_pkg::*;
  // ****************************************
  // signals, table and instances
  // ****************************************
  logic        clock_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, fire = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  dly = 4'h0;
  logic        watchdog_timeout_in, pready_out, pslverr_out, power_down_flag_out, watchdog_expiry_flag_out, e;
  logic [31:0] prdata_out, q, x;
  int          error_cnt = 0, num_checks = 0;
  localparam logic [11:0] RM = {MAIN_PAGE, 6'h3f, 2'h0}; // top main cell
  localparam logic [11:0] RS = {SPEC_PAGE, 6'h0f, 2'h0}; // top special cell
  localparam logic [11:0] RC = {CTRL_PAGE, 6'h05, 2'h0}; // first control cell
  typedef struct { op_t o; logic d; logic [7:0] i, rv, wv, sv, ev, es; } row_t;
  // op, dest, imm, reg, work, status in, result, status out
  row_t rows [8] = '{'{OP_ADD_REG, 1'b1, 8'h00, 8'h34, 8'h12, 8'h01, 8'h46, 8'h18},
    '{OP_ADD_REG_WITH_CARRY, 1'b0, 8'h00, 8'h34, 8'h12, 8'h01, 8'h47, 8'h18},
    '{OP_ADD_IMM, 1'b0, 8'h08, 8'h00, 8'hf8, 8'h01, 8'h00, 8'h1f},
    '{OP_ADD_IMM_WITH_CARRY, 1'b0, 8'h0e, 8'h00, 8'h00, 8'h01, 8'h0f, 8'h18},
    '{OP_SUB_REG_WITH_BORROW, 1'b0, 8'h00, 8'h05, 8'h03, 8'h01, 8'h02, 8'h1b},
    '{OP_SUB_REG_WITH_BORROW, 1'b1, 8'h00, 8'h01, 8'h02, 8'h01, 8'hff, 8'h18},
    '{OP_AND_REG, 1'b1, 8'h00, 8'haf, 8'h5a, 8'h03, 8'h0a, 8'h1b},
    '{OP_AND_IMM, 1'b0, 8'ha5, 8'h00, 8'h5a, 8'h03, 8'h00, 8'h1f}};

  mcu_alu_bit_datapath dut_u (.clock_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .watchdog_timeout_in, .prdata_out, .pready_out, .pslverr_out, .power_down_flag_out, .watchdog_expiry_flag_out);
  watchdog_pulse_model wdt_u (.clock_in, .rst_n_in, .fire_in(fire), .delay_in(dly), .timeout_out(watchdog_timeout_in));

  always #20 clock_in = ~clock_in; // 25 MHz

  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16); // bounded, a dead slave must not hang us
    chk({31'h0, pready_out}, 32'h1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // command word: page, address, immediate, bit, destination, op
  task automatic op(input op_t o, input logic d, input logic [2:0] b, input logic [7:0] i, input page_t g,
                    input logic [5:0] r);
    apb(1'b1, CMD_OFS, {6'h00, g, 2'h0, r, i, b, d, o});
  endtask

  // one timeout pulse from the stand-in, then let it settle
  task automatic bark(input logic [3:0] dl);
    @(posedge clock_in);
    fire <= 1'b1;
    dly <= dl;
    @(posedge clock_in);
    fire <= 1'b0;
    repeat (20) @(posedge clock_in);
  endtask

  // watchdog on the run itself
  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    stop_test;
  end

  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rc(STATUS_OFS, 32'h18);
    foreach (rows[k]) begin
      apb(1'b1, RM, {24'h0, rows[k].rv});
      apb(1'b1, WORK_OFS, {24'h0, rows[k].wv});
      apb(1'b1, STATUS_OFS, {24'h0, rows[k].sv});
      op(rows[k].o, rows[k].d, 3'h0, rows[k].i, PG_MAIN, 6'h3f);
      rc(rows[k].d ? RM : WORK_OFS, {24'h0, rows[k].ev});
      rc(rows[k].d ? WORK_OFS : RM, {24'h0, rows[k].d ? rows[k].wv : rows[k].rv});
      rc(STATUS_OFS, {24'h0, rows[k].es});
      rc(RESULT_OFS, {24'h0, rows[k].ev});
    end
    apb(1'b1, RS, 32'h0);
    x = 32'h0;
    for (int b = 0; b < 8; b++) begin
      op(OP_BIT_SET, 1'b1, 3'(b), 8'h00, PG_SPEC, 6'h0f);
      x[b] = 1'b1;
      rc(RS, x);
    end
    for (int b = 7; b >= 0; b--) begin
      op(OP_BIT_CLEAR, 1'b1, 3'(b), 8'h00, PG_SPEC, 6'h0f);
      x[b] = 1'b0;
      rc(RS, x);
    end
    op(OP_NOP, 1'b1, 3'h0, 8'h00, PG_MAIN, 6'h00);
    rc(STATUS_OFS, 32'h1f);
    apb(1'b0, {CTRL_PAGE, 6'h04, 2'h0}, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, RC, 32'h77);
    rc(RC, 32'h77);
    op(OP_ADD_REG, 1'b0, 3'h0, 8'h00, PG_CTRL, 6'h04);
    rc(STATUS_OFS, 32'h3f);
    apb(1'b1, STATUS_OFS, 32'h27);
    op(OP_AND_REG, 1'b0, 3'h0, 8'h00, PG_SPEC, 6'h10);
    rc(STATUS_OFS, 32'h3f);
    op(OP_HALT, 1'b0, 3'h0, 8'h00, PG_NONE, 6'h00);
    rc(STATUS_OFS, 32'h37);
    bark(4'h9);
    rc(STATUS_OFS, 32'h27);
    op(OP_WATCHDOG_CLEAR, 1'b0, 3'h0, 8'h00, PG_NONE, 6'h00);
    rc(STATUS_OFS, 32'h3f);
    bark(4'h0);
    chk({30'h0, power_down_flag_out, watchdog_expiry_flag_out}, 32'h2);
    stop_test;
  end
endmodule

// ===== bench/watchdog_pulse_model.sv
// stand-in for the watchdog counter: one timeout pulse after a chosen delay
// assumes the bench raises fire_in for one cycle per wanted timeout
`timescale 1ns/1ns
module watchdog_pulse_model (
  input  wire logic       clock_in,   // core clock
  input  wire logic       rst_n_in,   // active-low reset
  input  wire logic       fire_in,    // request one timeout
  input  wire logic [3:0] delay_in,   // extra cycles before the pulse
  output logic            timeout_out // one-cycle pulse, a level would clear every cycle
);
  logic [4:0] cnt_ff; // zero while idle
  // countdown, pulse when it reaches one
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff      <= 5'h00;
      timeout_out <= 1'b0;
    end else begin
      cnt_ff      <= fire_in ? {1'b0, delay_in} + 5'h01 : cnt_ff - {4'h0, cnt_ff != 5'h00};
      timeout_out <= (cnt_ff == 5'h01);
    end
  end
endmodule

// ===== logic/alu_bit_pkg.sv
// constants, field layouts and types shared by the alu and bit datapath
// assumes a single 25 MHz core clock and an apb master with 32-bit data
// Contract
// - addition: carry set on carry out, else clear
// - subtraction: carry is inverted borrow
// - dest bit 0 to work, 1 to register
// - main register page spans 0x00 to 0x3f
// - control page operands limited to 0x5..0xf
// - special page operands span 0x0 to 0xf
// - power-down flag: set power-up/clear-op, cleared halt
// - expiry flag: set power-up/clear/halt, cleared timeout
// - add reg with carry: reg+work+carry, flags
// - add reg: work+reg, no carry in, flags
// - add imm with carry into work, flags
// - add imm into work, carry ignored, flags
// - and reg: result to dest, zero only
// - and imm into work, zero only
// - bit clear: one bit to 0, flags kept
// - bit set: one bit to 1, flags kept
// - bit select indexes positions 0 to 7
// - nibble carry flag updated by add operations
// - sub with borrow: reg + ~work + carry

package alu_bit_pkg;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [11:0] CMD_OFS      = 12'h000; // write starts one operation
  localparam logic [11:0] WORK_OFS     = 12'h004; // work register
  localparam logic [11:0] STATUS_OFS   = 12'h008; // flags
  localparam logic [11:0] RESULT_OFS   = 12'h00c; // last result, read only
  localparam logic [3:0]  MAIN_PAGE    = 4'h1;    // addr[11:8] of main page window
  localparam logic [3:0]  CTRL_PAGE    = 4'h2;    // addr[11:8] of control page window
  localparam logic [3:0]  SPEC_PAGE    = 4'h3;    // addr[11:8] of special page window

  // ****************************************
  // register operand ranges
  // ****************************************
  localparam int         MAIN_DEPTH    = 64;      // 0x00..0x3f
  localparam int         SMALL_DEPTH   = 16;      // 0x0..0xf
  localparam logic [5:0] MAIN_LAST     = 6'h3f;
  localparam logic [5:0] CTRL_FIRST    = 6'h05;
  localparam logic [5:0] CTRL_LAST     = 6'h0f;
  localparam logic [5:0] SPEC_LAST     = 6'h0f;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int CARRY_BIT   = 0;
  localparam int NIBBLE_BIT  = 1;
  localparam int ZERO_BIT    = 2;
  localparam int PDOWN_BIT   = 3;
  localparam int EXPIRY_BIT  = 4;
  localparam int ERROR_BIT   = 5;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0018; // both power flags high

  // ****************************************
  // operations and command word
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD_REG, OP_ADD_REG_WITH_CARRY, OP_SUB_REG_WITH_BORROW,
    OP_ADD_IMM, OP_ADD_IMM_WITH_CARRY, OP_AND_REG, OP_AND_IMM,
    OP_BIT_SET, OP_BIT_CLEAR, OP_WATCHDOG_CLEAR, OP_HALT
  } op_t;

  typedef enum logic [1:0] {
    PG_MAIN, PG_CTRL, PG_SPEC, PG_NONE
  } page_t;

  // packed layout of the command register, lsb last
  typedef struct packed {
    logic [5:0] spare;     // bits 31:26
    page_t      page;      // bits 25:24
    logic [1:0] spare2;    // bits 23:22
    logic [5:0] reg_addr;  // bits 21:16
    logic [7:0] imm;       // bits 15:8
    logic [2:0] bit_sel;   // bits 7:5
    logic       dest;      // bit 4
    op_t        op;        // bits 3:0
  } cmd_t;

  // flags carried together
  typedef struct packed {
    logic zero;
    logic nibble;
    logic carry;
  } flags_t;

endpackage

// ===== logic/mcu_alu_bit_datapath.sv
// alu, bit-operation and status-flag datapath of an 8-bit core, reached over apb
// assumes an apb master on clock_in; the watchdog counter pulses its timeout in

`timescale 1ns/1ns

module mcu_alu_bit_datapath (
  input  wire logic        clock_in,              // 25 MHz core clock
  input  wire logic        rst_n_in,              // async active-low reset
  input  wire logic        psel_in,               // apb select
  input  wire logic        penable_in,            // apb access phase
  input  wire logic        pwrite_in,             // apb direction
  input  wire logic [11:0] paddr_in,              // apb byte address
  input  wire logic [31:0] pwdata_in,             // apb write data
  input  wire logic        watchdog_timeout_in,   // one-cycle timeout pulse
  output logic      [31:0] prdata_out,            // apb read data
  output logic             pready_out,            // apb ready
  output logic             pslverr_out,           // apb error
  output logic             power_down_flag_out,   // power-down flag level
  output logic             watchdog_expiry_flag_out // expiry flag level
);
  import alu_bit_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic       rst_meta_ff;                       // first stage, read only by second
  logic       rst_n_ff;                          // synchronised reset

  // two flops so release is clean with respect to clock_in
  // assertion stays asynchronous so a dead clock still clears the core
  // every other flop resets from rst_n_ff, never from the pin itself
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ****************************************
  // state
  // ****************************************
  // all pages reset to zero; only the power flags come up high
  logic [7:0]  main_page_ff [MAIN_DEPTH];        // main register page
  logic [7:0]  ctrl_page_ff [SMALL_DEPTH];       // control page, 0x5..0xf used
  logic [7:0]  spec_page_ff [SMALL_DEPTH];       // special page
  logic [7:0]  work_ff;                          // work register
  logic [7:0]  result_ff;                        // last computed result
  flags_t      flags_ff;                         // zero, nibble carry, carry
  logic        pdown_ff;                         // power-down flag
  logic        expiry_ff;                        // watchdog expiry flag
  logic        error_ff;                         // sticky refused-operand flag
  logic        ready_ff;                         // apb ready
  logic        slverr_ff;                        // apb error
  logic [31:0] rdata_ff;                         // apb read data

  // ****************************************
  // apb decode
  // ****************************************
  // the ready flop doubles as the wait-state marker: the edge that sees
  // access with ready already high is the one completion edge
  wire logic        access     = psel_in & penable_in;          // access phase
  wire logic        done       = access & ready_ff;             // transfer completes this edge
  wire logic        wr_done    = done & pwrite_in;              // write takes effect
  wire logic [3:0]  win        = paddr_in[11:8];                // page window select
  wire logic [5:0]  win_idx    = paddr_in[7:2];                 // word index inside window
  wire logic        sel_cmd    = (paddr_in == CMD_OFS);
  wire logic        sel_work   = (paddr_in == WORK_OFS);
  wire logic        sel_status = (paddr_in == STATUS_OFS);
  wire logic        sel_result = (paddr_in == RESULT_OFS);
  wire logic        sel_main   = (win == MAIN_PAGE) & (paddr_in[1:0] == 2'h0);
  wire logic        sel_ctrl   = (win == CTRL_PAGE) & (paddr_in[1:0] == 2'h0)
                                 & (win_idx >= CTRL_FIRST) & (win_idx <= CTRL_LAST);
  wire logic        sel_spec   = (win == SPEC_PAGE) & (paddr_in[1:0] == 2'h0)
                                 & (win_idx <= SPEC_LAST);
  wire logic        mapped     = sel_cmd | sel_work | sel_status | sel_result
                                 | sel_main | sel_ctrl | sel_spec;

  // ****************************************
  // command decode
  // ****************************************
  // a command takes effect on the write-completion edge, never at setup,
  // so an access phase that lasts long cannot run the op twice
  // ops that need no register ignore page and address and are never refused
  wire cmd_t        cmd        = cmd_t'(pwdata_in);            // layout of a command write
  wire logic        exec       = wr_done & sel_cmd;             // one operation, one cycle
  wire logic [5:0]  ra         = cmd.reg_addr;
  wire logic        main_ok    = (cmd.page == PG_MAIN) & (ra <= MAIN_LAST);
  wire logic        ctrl_ok    = (cmd.page == PG_CTRL) & (ra >= CTRL_FIRST)
                                 & (ra <= CTRL_LAST);
  wire logic        spec_ok    = (cmd.page == PG_SPEC) & (ra <= SPEC_LAST);
  wire logic        addr_ok    = main_ok | ctrl_ok | spec_ok;
  wire logic        uses_reg   = (cmd.op == OP_ADD_REG) | (cmd.op == OP_ADD_REG_WITH_CARRY)
                                 | (cmd.op == OP_SUB_REG_WITH_BORROW) | (cmd.op == OP_AND_REG)
                                 | (cmd.op == OP_BIT_SET) | (cmd.op == OP_BIT_CLEAR);
  wire logic        refused    = exec & uses_reg & ~addr_ok;    // bad operand address
  wire logic        run        = exec & ~refused;               // operation goes ahead

  // ****************************************
  // operand fetch
  // ****************************************
  wire logic [7:0]  reg_val    = main_ok ? main_page_ff[ra]
                               : ctrl_ok ? ctrl_page_ff[ra[3:0]]
                               : spec_ok ? spec_page_ff[ra[3:0]]
                               : 8'h00;

  // ****************************************
  // adder
  // ****************************************
  // one adder serves every add and the subtract; the subtract feeds ~work
  // the nibble sum is a separate 5-bit add so the carry out of bit 3 is exact
  // rather than rebuilt from an xor of result and operands
  wire logic        is_sub     = (cmd.op == OP_SUB_REG_WITH_BORROW);
  wire logic        is_imm_add = (cmd.op == OP_ADD_IMM) | (cmd.op == OP_ADD_IMM_WITH_CARRY);
  wire logic        use_cin    = (cmd.op == OP_ADD_REG_WITH_CARRY)
                                 | (cmd.op == OP_ADD_IMM_WITH_CARRY)
                                 | is_sub;
  wire logic [7:0]  add_a      = is_imm_add ? cmd.imm : reg_val;
  wire logic [7:0]  add_b      = is_sub ? ~work_ff : work_ff;
  wire logic        cin        = use_cin & flags_ff.carry;
  wire logic [4:0]  low_sum    = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
  wire logic [8:0]  full_sum   = {1'b0, add_a} + {1'b0, add_b} + {8'h00, cin};
  wire logic        carry_out  = full_sum[8];
  wire logic        nibble_out = low_sum[4];

  // ****************************************
  // bit operations
  // ****************************************
  logic [7:0] bit_mask;                          // one-hot from bit select

  // one generate loop builds the one-hot mask over positions 0..7
  // a select past 7 cannot occur: the field is three bits wide
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign bit_mask[gi] = (cmd.bit_sel == 3'(gi));
    end
  endgenerate

  // ****************************************
  // result and write-back selection
  // ****************************************
  logic [7:0] op_result;                         // value produced by the operation
  logic       is_arith;                          // updates zero, nibble and carry
  logic       is_logic;                          // updates zero only
  logic       to_reg;                            // result goes to the operand register

  // pick result; flags and destination are chosen per operation
  // immediate ops always land in the work register, bit ops in the page
  always_comb begin
    op_result = 8'h00;
    is_arith  = 1'b0;
    is_logic  = 1'b0;
    to_reg    = 1'b0;
    case (cmd.op)
      OP_ADD_REG, OP_ADD_REG_WITH_CARRY, OP_SUB_REG_WITH_BORROW: begin
        op_result = full_sum[7:0];
        is_arith  = 1'b1;
        to_reg    = cmd.dest;
      end
      OP_ADD_IMM, OP_ADD_IMM_WITH_CARRY: begin
        op_result = full_sum[7:0];
        is_arith  = 1'b1;
      end
      OP_AND_REG: begin
        op_result = work_ff & reg_val;
        is_logic  = 1'b1;
        to_reg    = cmd.dest;
      end
      OP_AND_IMM: begin
        op_result = work_ff & cmd.imm;
        is_logic  = 1'b1;
      end
      OP_BIT_SET: begin
        op_result = reg_val | bit_mask;
        to_reg    = 1'b1;
      end
      OP_BIT_CLEAR: begin
        op_result = reg_val & ~bit_mask;
        to_reg    = 1'b1;
      end
      default: begin
        op_result = 8'h00;                       // nop, watchdog clear, halt
      end
    endcase
  end

  wire logic       writes_work = run & (is_arith | is_logic) & ~to_reg;
  wire logic       writes_reg  = run & to_reg;
  wire logic       zero_out    = (op_result == 8'h00);

  // ****************************************
  // register pages
  // ****************************************
  // software and operations never write in the same cycle: a command write
  // is itself the only apb write of that edge
  wire logic       sw_main = wr_done & sel_main;
  wire logic       sw_ctrl = wr_done & sel_ctrl;
  wire logic       sw_spec = wr_done & sel_spec;

  // a refused command writes nothing here because run is low
  // one write port per page keeps each array a simple memory
  // main page, 64 bytes
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < MAIN_DEPTH; i++) main_page_ff[i] <= 8'h00;
    end else if (sw_main) begin
      main_page_ff[win_idx] <= pwdata_in[7:0];
    end else if (writes_reg && main_ok) begin
      main_page_ff[ra] <= op_result;
    end
  end

  // control and special pages, 16 bytes each
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < SMALL_DEPTH; i++) begin
        ctrl_page_ff[i] <= 8'h00;
        spec_page_ff[i] <= 8'h00;
      end
    end else begin
      if (sw_ctrl) begin
        ctrl_page_ff[win_idx[3:0]] <= pwdata_in[7:0];
      end else if (writes_reg && ctrl_ok) begin
        ctrl_page_ff[ra[3:0]] <= op_result;
      end
      if (sw_spec) begin
        spec_page_ff[win_idx[3:0]] <= pwdata_in[7:0];
      end else if (writes_reg && spec_ok) begin
        spec_page_ff[ra[3:0]] <= op_result;
      end
    end
  end

  // ****************************************
  // work register and last result
  // ****************************************
  // result_ff tracks every executed op, also those whose target is a page
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      work_ff   <= 8'h00;
      result_ff <= 8'h00;
    end else begin
      if (wr_done && sel_work) begin
        work_ff <= pwdata_in[7:0];
      end else if (writes_work) begin
        work_ff <= op_result;
      end
      if (run) begin
        result_ff <= op_result;
      end
    end
  end

  // ****************************************
  // arithmetic flags
  // ****************************************
  flags_t nxt_flags;                             // next zero, nibble, carry

  // bit ops and halt leave flags alone; logic ops touch zero only
  // software may preload carry, nibble and zero to set up a carry chain
  // a status write and an op cannot meet: both need the one apb write
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_done && sel_status) begin
      nxt_flags.carry  = pwdata_in[CARRY_BIT];
      nxt_flags.nibble = pwdata_in[NIBBLE_BIT];
      nxt_flags.zero   = pwdata_in[ZERO_BIT];
    end else if (run && is_arith) begin
      nxt_flags.carry  = carry_out;
      nxt_flags.nibble = nibble_out;
      nxt_flags.zero   = zero_out;
    end else if (run && is_logic) begin
      nxt_flags.zero   = zero_out;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ****************************************
  // power flags and refusal flag
  // ****************************************
  wire logic do_clear = run & (cmd.op == OP_WATCHDOG_CLEAR);
  wire logic do_halt  = run & (cmd.op == OP_HALT);
  wire logic err_w1c  = wr_done & sel_status & pwdata_in[ERROR_BIT];

  // reset is power-up here, so both power flags come up high
  // there is no separate power-on detect; any reset counts as power-up
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pdown_ff  <= 1'b1;
      expiry_ff <= 1'b1;
      error_ff  <= 1'b0;
    end else begin
      if (do_clear) begin
        pdown_ff <= 1'b1;
      end else if (do_halt) begin
        pdown_ff <= 1'b0;
      end
      // the instruction that sets wins over a timeout in the same cycle
      if (do_clear || do_halt) begin
        expiry_ff <= 1'b1;
      end else if (watchdog_timeout_in) begin
        expiry_ff <= 1'b0;
      end
      // the refusal flag is sticky until software writes one to its bit
      // a new refusal wins over a write-one clear
      if (refused) begin
        error_ff <= 1'b1;
      end else if (err_w1c) begin
        error_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // apb answer
  // ****************************************
  logic [31:0] rd_mux;                           // read data for the addressed word

  // read selection, unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cmd) begin
      rd_mux = 32'h0000_0000;
    end else if (sel_work) begin
      rd_mux = {24'h000000, work_ff};
    end else if (sel_status) begin
      rd_mux = {26'h0000000, error_ff, expiry_ff, pdown_ff,
                flags_ff.zero, flags_ff.nibble, flags_ff.carry};
    end else if (sel_result) begin
      rd_mux = {24'h000000, result_ff};
    end else if (sel_main) begin
      rd_mux = {24'h000000, main_page_ff[win_idx]};
    end else if (sel_ctrl) begin
      rd_mux = {24'h000000, ctrl_page_ff[win_idx[3:0]]};
    end else if (sel_spec) begin
      rd_mux = {24'h000000, spec_page_ff[win_idx[3:0]]};
    end
  end

  // one wait state keeps every bus output on a flop
  // exactly one wait on every access; a master need not count it
  // read data is zero outside its single cycle so stale bytes never leak
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ready_ff  <= 1'b0;
      slverr_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      ready_ff  <= access & ~ready_ff;
      slverr_ff <= access & ~ready_ff & ~mapped;
      rdata_ff  <= (access && !ready_ff && !pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // plain wires from flops; nothing combinational reaches a pin
  assign prdata_out               = rdata_ff;
  assign pready_out               = ready_ff;
  assign pslverr_out              = slverr_ff;
  assign power_down_flag_out      = pdown_ff;
  assign watchdog_expiry_flag_out = expiry_ff;

endmodule
